//--- fec_pkg.sv
// Shared types and constants of the flow and exception control block.
package fec_pkg;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_SAVED = 8'h04;
	localparam logic [7:0] REG_VBASE = 8'h08;
	localparam logic [7:0] REG_WLIM = 8'h0c;
	localparam logic [7:0] REG_PC = 8'h10;
	localparam logic [7:0] REG_LAST_EXC = 8'h14;
	localparam int ST_PRIORITY_THRESHOLD_LSB = 0;
	localparam int ST_IE_BIT = 6;
	localparam int ST_CWP_LSB = 7;
	localparam int WL_LO_LSB = 0;
	localparam int WL_HI_LSB = 8;
	localparam logic [4:0] LOWEST_WINDOW_LIMIT_RST = 5'h01;
	localparam logic [4:0] HI_LIMIT_RST = 5'h0e;
	localparam logic [5:0] PRIORITY_THRESHOLD_RST = 6'h3f;
	localparam logic [31:0] VBASE_RST = 32'h0000_0000;
	localparam logic [31:0] PC_RST = 32'h0000_0000;
	localparam logic [5:0] EXC_UNDERFLOW = 6'h01;
	localparam logic [5:0] EXC_OVERFLOW = 6'h02;
	localparam logic [4:0] PTR_BASE_IDX = 5'h10;
	localparam logic [4:0] SP_IDX = 5'h0e;
	localparam logic [31:0] INSN_BYTES = 32'h0000_0002;
	localparam logic [31:0] VEC_ENTRY_BYTES = 32'h0000_0004;

	typedef enum logic [4:0] {
		OP_NONE, OP_PTR_LOAD, OP_PTR_WRITE, OP_STK_LOAD, OP_STK_WRITE,
		OP_BYTE_WR_S, OP_HALF_WR_S, OP_BYTE_WR_D, OP_HALF_WR_D,
		OP_STK_BYTE_WR, OP_STK_HALF_WR, OP_PC_JUMP, OP_PC_SUB_JUMP,
		OP_REG_JUMP, OP_REG_CALL, OP_TRAP, OP_EXC_RETURN, OP_SKIP,
		OP_PREFIX, OP_SAVE, OP_RESTORE
	} fec_op_t;

	typedef struct packed {
		fec_op_t op;
		logic [10:0] imm;
		logic [4:0] reg_idx;
		logic [31:0] reg_val;
		logic [31:0] src_val;
		logic cond;
	} fec_issue_t;

	typedef struct packed {
		logic [4:0] window_pointer;
		logic ie;
		logic [5:0] priority_threshold;
	} fec_status_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
		logic wr;
		logic rd;
	} fec_mem_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_VEC = 2'b10
	} fec_state_t;
endpackage

//--- fec_flow_ctrl.sv
// Program flow, indexed addressing and exception entry of the core.
`timescale 1ns/1ps
`default_nettype none
module fec_flow_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire fec_pkg::fec_issue_t issue,
	output logic issue_ready,
	output logic [31:0] pc_q,
	output fec_pkg::fec_mem_t mem_q,
	output logic cancel_q,
	output logic fault_q,
	output logic link_we_q,
	output logic [31:0] link_data_q,
	output logic vec_rd_q,
	output logic [31:0] vec_addr_q,
	input wire logic [31:0] vec_rdata,
	input wire logic vec_rvalid,
	input wire logic irq,
	input wire logic [5:0] irq_number,
	output logic [4:0] window_q,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	function automatic logic [31:0] word_addr(input logic [31:0] base,
		input logic [31:0] idx);
		word_addr = {base[31:2], 2'b00} + {idx[29:0], 2'b00};
	endfunction

	function automatic logic [3:0] lane_en(input logic [1:0] lane,
		input logic half);
		if (half) begin
			lane_en = lane[1] ? 4'hc : 4'h3;
		end else begin
			lane_en = 4'h1 << lane;
		end
	endfunction

	fec_pkg::fec_state_t st_q;
	fec_pkg::fec_status_t status_q, saved_q;
	logic [31:0] vbase_q;
	logic [4:0] lo_q, hi_q;
	logic [5:0] last_exc_q;
	logic irq_m_q, irq_s_q;
	logic [5:0] num_m_q, num_s_q;
	logic slot_q, skip_q, cancel2_q, pfx_q;
	logic [31:0] tgt_q;
	logic [10:0] k_q;

	logic accept, cancel_now, exec, safe, take_irq, exc_go, underflow;
	logic [5:0] exc_num;
	logic [31:0] resume, idx, ea, jtgt;
	logic legal, is_jump, is_call;
	fec_pkg::fec_mem_t mem_d;

	// Both request inputs come from another block's logic on a pin path,
	// so they are synchronised before any decision reads them.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_m_q <= 1'b0;
			irq_s_q <= 1'b0;
			num_m_q <= 6'h00;
			num_s_q <= 6'h00;
		end else begin
			irq_m_q <= irq;
			irq_s_q <= irq_m_q;
			num_m_q <= irq_number;
			num_s_q <= num_m_q;
		end
	end

	// Interrupts only land on a clean boundary, never between a jump and
	// its slot or inside a skipped pair, so the resume point is exact.
	assign safe = !slot_q && !skip_q && !cancel2_q && !pfx_q;
	assign take_irq = (st_q == fec_pkg::ST_IDLE) && safe && irq_s_q &&
		status_q.ie && (num_s_q < status_q.priority_threshold);
	assign issue_ready = (st_q == fec_pkg::ST_IDLE) && !take_irq;
	assign accept = issue_valid && issue_ready;
	assign cancel_now = skip_q || cancel2_q;
	assign exec = accept && !cancel_now;

	always_comb begin
		mem_d = '0;
		idx = 32'h0;
		ea = 32'h0;
		legal = 1'b1;
		jtgt = 32'h0;
		is_jump = 1'b0;
		is_call = 1'b0;
		exc_go = 1'b0;
		underflow = 1'b0;
		exc_num = num_s_q;
		resume = pc_q;
		if (pfx_q) begin
			idx = {{16{k_q[10]}}, k_q, issue.imm[4:0]};
		end
		mem_d.wdata = issue.src_val;
		if (exec) begin
			unique case (issue.op)
			fec_pkg::OP_PTR_LOAD, fec_pkg::OP_PTR_WRITE: begin
				legal = issue.reg_idx[4:2] ==
					fec_pkg::PTR_BASE_IDX[4:2];
				if (!pfx_q) begin
					idx = {{27{issue.imm[4]}}, issue.imm[4:0]};
				end
				mem_d.addr = word_addr(issue.reg_val, idx);
				mem_d.be = 4'hf;
				mem_d.wdata = issue.src_val;
				mem_d.rd = legal && (issue.op == fec_pkg::OP_PTR_LOAD);
				mem_d.wr = legal && (issue.op == fec_pkg::OP_PTR_WRITE);
			end
			fec_pkg::OP_STK_LOAD, fec_pkg::OP_STK_WRITE: begin
				legal = issue.reg_idx == fec_pkg::SP_IDX;
				if (pfx_q) begin
					idx = {16'h0000, k_q, issue.imm[4:0]};
				end else begin
					idx = {24'h000000, issue.imm[7:0]};
				end
				mem_d.addr = word_addr(issue.reg_val, idx);
				mem_d.be = 4'hf;
				mem_d.rd = legal && (issue.op == fec_pkg::OP_STK_LOAD);
				mem_d.wr = legal && (issue.op == fec_pkg::OP_STK_WRITE);
			end
			fec_pkg::OP_BYTE_WR_S, fec_pkg::OP_HALF_WR_S: begin
				mem_d.addr = word_addr(issue.reg_val, idx);
				mem_d.be = lane_en(issue.imm[1:0],
					issue.op == fec_pkg::OP_HALF_WR_S);
				mem_d.wr = 1'b1;
			end
			fec_pkg::OP_BYTE_WR_D, fec_pkg::OP_HALF_WR_D: begin
				mem_d.addr = word_addr(issue.reg_val, idx);
				mem_d.be = lane_en(issue.reg_val[1:0],
					issue.op == fec_pkg::OP_HALF_WR_D);
				mem_d.wr = 1'b1;
			end
			fec_pkg::OP_STK_BYTE_WR, fec_pkg::OP_STK_HALF_WR: begin
				legal = issue.reg_idx == fec_pkg::SP_IDX;
				if (issue.op == fec_pkg::OP_STK_BYTE_WR) begin
					ea = issue.reg_val + {22'h0, issue.imm[9:0]};
				end else begin
					ea = issue.reg_val + {22'h0, issue.imm[8:0], 1'b0};
				end
				mem_d.addr = {ea[31:2], 2'b00};
				mem_d.be = lane_en(ea[1:0],
					issue.op == fec_pkg::OP_STK_HALF_WR);
				mem_d.wr = legal;
			end
			fec_pkg::OP_PC_JUMP, fec_pkg::OP_PC_SUB_JUMP: begin
				// The offset is counted from the jump itself plus one
				// instruction, which gives the asymmetric reach.
				jtgt = pc_q + {{20{issue.imm[10]}}, issue.imm, 1'b0} +
					fec_pkg::INSN_BYTES;
				is_jump = 1'b1;
				is_call = issue.op == fec_pkg::OP_PC_SUB_JUMP;
			end
			fec_pkg::OP_REG_JUMP, fec_pkg::OP_REG_CALL: begin
				jtgt = {issue.reg_val[30:0], 1'b0};
				is_jump = 1'b1;
				is_call = issue.op == fec_pkg::OP_REG_CALL;
			end
			fec_pkg::OP_TRAP: begin
				exc_go = 1'b1;
				exc_num = issue.imm[5:0];
				resume = pc_q + fec_pkg::INSN_BYTES;
			end
			fec_pkg::OP_SAVE: begin
				if (status_q.window_pointer == lo_q && status_q.ie &&
					status_q.priority_threshold > fec_pkg::EXC_UNDERFLOW) begin
					exc_go = 1'b1;
					underflow = 1'b1;
					exc_num = fec_pkg::EXC_UNDERFLOW;
					resume = pc_q + fec_pkg::INSN_BYTES;
				end
			end
			fec_pkg::OP_RESTORE: begin
				if (status_q.window_pointer == hi_q) begin
					exc_go = 1'b1;
					exc_num = fec_pkg::EXC_OVERFLOW;
					resume = pc_q + fec_pkg::INSN_BYTES;
				end
			end
			default: begin
			end
			endcase
		end
	end

	// Program counter, delay slot, skip and prefix tracking.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc_q <= fec_pkg::PC_RST;
			slot_q <= 1'b0;
			tgt_q <= 32'h0;
			skip_q <= 1'b0;
			cancel2_q <= 1'b0;
			pfx_q <= 1'b0;
			k_q <= 11'h000;
			link_we_q <= 1'b0;
			link_data_q <= 32'h0;
			cancel_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			link_we_q <= 1'b0;
			cancel_q <= accept && cancel_now;
			fault_q <= exec && !legal;
			if (take_irq || exc_go) begin
				link_we_q <= 1'b1;
				link_data_q <= {1'b0, resume[31:1]};
				slot_q <= 1'b0;
				skip_q <= 1'b0;
				cancel2_q <= 1'b0;
				pfx_q <= 1'b0;
			end else if (st_q == fec_pkg::ST_VEC && vec_rvalid) begin
				pc_q <= {vec_rdata[30:0], 1'b0};
			end else if (accept) begin
				skip_q <= exec && issue.op == fec_pkg::OP_SKIP &&
					issue.cond;
				cancel2_q <= skip_q &&
					issue.op == fec_pkg::OP_PREFIX;
				pfx_q <= exec && issue.op == fec_pkg::OP_PREFIX;
				if (exec && issue.op == fec_pkg::OP_PREFIX) begin
					k_q <= issue.imm;
				end
				if (exec && issue.op == fec_pkg::OP_EXC_RETURN) begin
					pc_q <= {issue.reg_val[30:0], 1'b0};
					slot_q <= 1'b0;
				end else if (slot_q) begin
					pc_q <= tgt_q;
					slot_q <= 1'b0;
				end else begin
					pc_q <= pc_q + fec_pkg::INSN_BYTES;
					slot_q <= is_jump;
					tgt_q <= jtgt;
				end
				if (is_call) begin
					link_we_q <= 1'b1;
					link_data_q <= pc_q[31:1] + 32'h0000_0002;
				end
			end
		end
	end

	// Status, saved status and window pointer.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_q <= '{window_pointer: fec_pkg::HI_LIMIT_RST, ie: 1'b0,
				priority_threshold: fec_pkg::PRIORITY_THRESHOLD_RST};
			saved_q <= '0;
			last_exc_q <= 6'h00;
		end else if (take_irq || exc_go) begin
			saved_q <= status_q;
			if (!underflow) begin
				status_q.window_pointer <= status_q.window_pointer - 5'h01;
			end else begin
				status_q.window_pointer <= status_q.window_pointer - 5'h01;
			end
			if (exc_go && issue.op == fec_pkg::OP_RESTORE) begin
				status_q.window_pointer <= status_q.window_pointer;
			end
			status_q.ie <= 1'b0;
			status_q.priority_threshold <= exc_num;
			last_exc_q <= exc_num;
		end else if (exec && issue.op == fec_pkg::OP_EXC_RETURN) begin
			status_q <= saved_q;
		end else if (exec && issue.op == fec_pkg::OP_SAVE) begin
			status_q.window_pointer <= status_q.window_pointer - 5'h01;
		end else if (exec && issue.op == fec_pkg::OP_RESTORE) begin
			status_q.window_pointer <= status_q.window_pointer + 5'h01;
		end else if (reg_wr && reg_addr == fec_pkg::REG_STATUS) begin
			status_q.priority_threshold <= reg_wdata[fec_pkg::ST_PRIORITY_THRESHOLD_LSB +: 6];
			status_q.ie <= reg_wdata[fec_pkg::ST_IE_BIT];
			status_q.window_pointer <= reg_wdata[fec_pkg::ST_CWP_LSB +: 5];
		end else if (reg_wr && reg_addr == fec_pkg::REG_SAVED) begin
			saved_q <= reg_wdata[11:0];
		end
	end

	// Vector fetch sequencer; the core is held off while it runs.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= fec_pkg::ST_IDLE;
			vec_rd_q <= 1'b0;
			vec_addr_q <= 32'h0;
		end else begin
			vec_rd_q <= 1'b0;
			unique case (st_q)
			fec_pkg::ST_IDLE: begin
				if (take_irq || exc_go) begin
					vec_rd_q <= 1'b1;
					vec_addr_q <= vbase_q + {24'h0, exc_num, 2'b00};
					st_q <= fec_pkg::ST_VEC;
				end
			end
			fec_pkg::ST_VEC: begin
				if (vec_rvalid) begin
					st_q <= fec_pkg::ST_IDLE;
				end
			end
			endcase
		end
	end

	// Memory request goes out registered, one cycle after the issue.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_q <= '0;
		end else begin
			mem_q <= mem_d;
		end
	end

	// Software-visible configuration and read port.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vbase_q <= fec_pkg::VBASE_RST;
			lo_q <= fec_pkg::LOWEST_WINDOW_LIMIT_RST;
			hi_q <= fec_pkg::HI_LIMIT_RST;
			reg_rdata <= 32'h0;
		end else begin
			if (reg_wr && reg_addr == fec_pkg::REG_VBASE) begin
				vbase_q <= {reg_wdata[31:2], 2'b00};
			end
			if (reg_wr && reg_addr == fec_pkg::REG_WLIM) begin
				lo_q <= reg_wdata[fec_pkg::WL_LO_LSB +: 5];
				hi_q <= reg_wdata[fec_pkg::WL_HI_LSB +: 5];
			end
			reg_rdata <= 32'h0;
			if (reg_rd) begin
				unique case (reg_addr)
				fec_pkg::REG_STATUS: reg_rdata <= {20'h0, status_q};
				fec_pkg::REG_SAVED: reg_rdata <= {20'h0, saved_q};
				fec_pkg::REG_VBASE: reg_rdata <= vbase_q;
				fec_pkg::REG_WLIM: reg_rdata <= {19'h0, hi_q, 3'h0, lo_q};
				fec_pkg::REG_PC: reg_rdata <= pc_q;
				fec_pkg::REG_LAST_EXC: reg_rdata <= {26'h0, last_exc_q};
				default: reg_rdata <= 32'h0;
				endcase
			end
		end
	end

	assign window_q = status_q.window_pointer;
endmodule
`default_nettype wire

//--- fec_flow_ctrl_asserts.sv
// Port-level checks of the flow and exception control block.
`timescale 1ns/1ps
`default_nettype none
module fec_flow_ctrl_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire fec_pkg::fec_issue_t issue,
	input wire logic issue_ready,
	input wire logic [31:0] pc_q,
	input wire fec_pkg::fec_mem_t mem_q,
	input wire logic fault_q,
	input wire logic link_we_q,
	input wire logic vec_rd_q,
	input wire logic [31:0] vec_addr_q,
	input wire logic [31:0] vec_rdata,
	input wire logic vec_rvalid,
	input wire logic [4:0] window_q,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic fetch_q;
	logic restore_q;
	// Tracks an open vector fetch and a restore accepted one cycle back.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fetch_q <= 1'b0;
			restore_q <= 1'b0;
		end else begin
			restore_q <= issue_valid && issue_ready &&
				issue.op == fec_pkg::OP_RESTORE;
			if (vec_rd_q) begin
				fetch_q <= 1'b1;
			end else if (vec_rvalid) begin
				fetch_q <= 1'b0;
			end
		end
	end
	AST_VEC_ALIGN: assert property (vec_rd_q |-> vec_addr_q[1:0] == 2'b00)
		else $error("vector read not on an entry boundary");
	AST_VEC_LINK: assert property (vec_rd_q |-> link_we_q)
		else $error("exception entry without link write");
	AST_VEC_LOAD: assert property (vec_rvalid |=> pc_q == ($past(vec_rdata) << 1))
		else $error("handler pc is not the doubled entry");
	AST_VEC_HOLD: assert property ((vec_rd_q || fetch_q) |-> !issue_ready)
		else $error("issue accepted during vector fetch");
	AST_VEC_PULSE: assert property (vec_rd_q |=> !vec_rd_q)
		else $error("vector read longer than one cycle");
	AST_MEM_ALIGN: assert property ((mem_q.wr || mem_q.rd) |-> mem_q.addr[1:0] == 2'b00)
		else $error("memory access not word aligned");
	AST_FAULT_QUIET: assert property (fault_q |-> !(mem_q.wr || mem_q.rd))
		else $error("faulting access reached memory");
	AST_WIN_OPEN: assert property ((vec_rd_q && !restore_q) |-> window_q == $past(window_q) - 5'h01)
		else $error("handler window not freshly opened");
	AST_WIN_KEEP: assert property ((vec_rd_q && restore_q) |-> window_q == $past(window_q))
		else $error("overflow entry moved the window");
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	cover property (vec_rvalid ##1 issue_ready);
	cover property (fault_q);
	cover property (mem_q.wr);
endmodule
`default_nettype wire

//--- fec_partner.sv
// Vector table memory and interrupt requester facing the block.
`timescale 1ns/1ps
`default_nettype none
module fec_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic vec_rd_q,
	input wire logic [31:0] vec_addr_q,
	output logic [31:0] vec_rdata,
	output logic vec_rvalid,
	input wire logic req_on,
	input wire logic [5:0] req_num,
	output logic irq,
	output logic [5:0] irq_number
);
	logic [2:0] wait_q;
	logic busy_q;
	logic slow_q;
	// Answers alternate prompt and slow; idle data toggles so no stale match.
	always_ff @(posedge clk) begin
		vec_rvalid <= 1'b0;
		vec_rdata <= ~vec_rdata;
		if (!rst_n) begin
			busy_q <= 1'b0;
			slow_q <= 1'b0;
			vec_rdata <= 32'h0;
		end else if (vec_rd_q) begin
			busy_q <= 1'b1;
			slow_q <= ~slow_q;
			wait_q <= slow_q ? 3'h5 : 3'h0;
		end else if (busy_q && wait_q == 3'h0) begin
			busy_q <= 1'b0;
			vec_rvalid <= 1'b1;
			vec_rdata <= 32'h800 + vec_addr_q[31:2];
		end else if (busy_q) begin
			wait_q <= wait_q - 3'h1;
		end
	end
	// The request is a held level; a released index is inverted each cycle.
	always_ff @(posedge clk) begin
		irq <= rst_n & req_on;
		irq_number <= !rst_n ? 6'h00 :
			(req_on ? req_num : ~irq_number);
	end
endmodule
`default_nettype wire

//--- fec_flow_ctrl_test.sv
// Self-checking bench of the flow and exception control block.
`timescale 1ns/1ps
`default_nettype none
module fec_flow_ctrl_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic issue_valid = 1'b0;
	fec_pkg::fec_issue_t issue = '0;
	logic issue_ready, cancel_q, fault_q, link_we_q, vec_rd_q, vec_rvalid, irq;
	logic [31:0] pc_q, link_data_q, vec_addr_q, vec_rdata, reg_rdata, p0;
	logic [31:0] last_link, last_vaddr;
	fec_pkg::fec_mem_t mem_q, last_mem;
	logic [5:0] irq_number;
	logic [4:0] window_q;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, req_on = 1'b0;
	logic [5:0] req_num = 6'h00;
	int n_errors = 0, compares = 0, cyc = 0, nvd = 0;
	int nmem = 0, ncan = 0, nflt = 0, nvec = 0;
	always #2 clk = ~clk;
	fec_flow_ctrl uut (.clk, .rst_n, .issue_valid, .issue, .issue_ready, .pc_q,
		.mem_q, .cancel_q, .fault_q, .link_we_q, .link_data_q, .vec_rd_q,
		.vec_addr_q, .vec_rdata, .vec_rvalid, .irq, .irq_number, .window_q,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	fec_partner far (.clk, .rst_n, .vec_rd_q, .vec_addr_q, .vec_rdata,
		.vec_rvalid, .req_on, .req_num, .irq, .irq_number);
	// Registered outputs are sampled before the edge updates land.
	always @(posedge clk) begin
		if (mem_q.wr || mem_q.rd) begin
			last_mem <= mem_q;
			nmem <= nmem + 1;
		end
		if (link_we_q) last_link <= link_data_q;
		if (vec_rd_q) begin
			last_vaddr <= vec_addr_q;
			nvec <= nvec + 1;
		end
		if (cancel_q) ncan <= ncan + 1;
		if (fault_q) nflt <= nflt + 1;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
			input string nm);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e, nm);
	endtask
	task automatic iss(input fec_pkg::fec_op_t op, input logic [10:0] im = 11'h0,
			input logic [31:0] rv = 32'h0,
			input logic [4:0] ri = fec_pkg::SP_IDX, input logic c = 1'b0);
		int k;
		k = 0;
		@(posedge clk);
		issue_valid <= 1'b1;
		issue <= '{op, im, ri, rv, 32'ha1b2c3d4, c};
		#1;
		while (issue_ready !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		@(posedge clk);
		issue_valid <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic exc(input logic [5:0] n, input logic [31:0] st);
		int k;
		k = 0;
		while ((nvec == nvd || issue_ready !== 1'b1) && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		@(posedge clk);
		#1;
		nvd = nvec;
		chk(last_vaddr, {24'h0, n, 2'b00}, "vector address");
		chk(pc_q, (32'h800 + n) << 1, "handler pc");
		rdc(fec_pkg::REG_STATUS, st, "entry status");
	endtask
	task automatic t_flow();
		rdc(fec_pkg::REG_STATUS, 32'h0000073f, "status reset");
		wr(8'h20, 32'hffffffff);
		rdc(8'h20, 32'h0, "unmapped");
		iss(fec_pkg::OP_PC_JUMP, 11'h3ff);
		chk(pc_q, 32'h2, "slot pc");
		iss(fec_pkg::OP_NONE);
		chk(pc_q, 32'h800, "forward reach");
		iss(fec_pkg::OP_PC_JUMP, 11'h400);
		iss(fec_pkg::OP_NONE);
		chk(pc_q, 32'h800 - 32'd2046, "backward reach");
		iss(fec_pkg::OP_PC_SUB_JUMP, 11'h001);
		chk(last_link, 32'h3, "sub link");
		iss(fec_pkg::OP_NONE);
		chk(pc_q, 32'h6, "sub target");
		iss(fec_pkg::OP_REG_CALL, 11'h0, 32'h300);
		chk(last_link, 32'h5, "call link");
		iss(fec_pkg::OP_NONE);
		chk(pc_q, 32'h600, "register target");
		$display("flow test done");
	endtask
	task automatic t_mem();
		int m0;
		iss(fec_pkg::OP_PTR_LOAD, 11'h01f, 32'h1003, fec_pkg::PTR_BASE_IDX);
		chk({last_mem.addr, last_mem.rd}, {32'h0ffc, 1'b1}, "ptr load");
		iss(fec_pkg::OP_STK_LOAD, 11'h0ff, 32'h2002);
		chk({last_mem.addr, last_mem.rd}, {32'h23fc, 1'b1}, "stk load");
		iss(fec_pkg::OP_STK_BYTE_WR, 11'h3ff, 32'h2000);
		chk({last_mem.addr, last_mem.be}, {32'h23fc, 4'h8}, "stk byte");
		iss(fec_pkg::OP_STK_HALF_WR, 11'h1ff, 32'h2000);
		chk({last_mem.addr, last_mem.be}, {32'h23fc, 4'hc}, "stk half");
		iss(fec_pkg::OP_BYTE_WR_D, 11'h0, 32'h3002, 5'h03);
		chk({last_mem.be, last_mem.wdata}, {4'h4, 32'ha1b2c3d4}, "dyn byte");
		m0 = nmem;
		iss(fec_pkg::OP_PTR_WRITE, 11'h0, 32'h1000, 5'h05);
		chk({nflt, nmem - m0}, {32'd1, 32'd0}, "bad base");
		m0 = nmem;
		iss(fec_pkg::OP_SKIP, 11'h0, 32'h0, fec_pkg::SP_IDX, 1'b1);
		iss(fec_pkg::OP_PREFIX, 11'h7ff);
		iss(fec_pkg::OP_PTR_LOAD, 11'h001, 32'h1000, fec_pkg::PTR_BASE_IDX);
		chk({ncan, nmem - m0}, {32'd2, 32'd0}, "pair cancel");
		iss(fec_pkg::OP_SKIP);
		iss(fec_pkg::OP_PTR_LOAD, 11'h001, 32'h1000, fec_pkg::PTR_BASE_IDX);
		chk({ncan, last_mem.addr}, {32'd2, 32'h1004}, "skip kept");
		$display("memory test done");
	endtask
	task automatic t_exc();
		p0 = pc_q;
		iss(fec_pkg::OP_TRAP, 11'h005);
		chk(last_link, (p0 + 32'h2) >> 1, "trap link");
		exc(6'h05, 32'h00000685);
		rdc(fec_pkg::REG_SAVED, 32'h0000073f, "saved status");
		iss(fec_pkg::OP_EXC_RETURN, 11'h0, last_link);
		chk(pc_q, p0 + 32'h2, "return pc");
		wr(fec_pkg::REG_STATUS, 32'h0000074a);
		req_num <= 6'h0a;
		req_on <= 1'b1;
		repeat (12) @(posedge clk);
		chk(nvec, nvd, "irq at threshold");
		req_num <= 6'h03;
		exc(6'h03, 32'h00000683);
		@(posedge clk);
		req_on <= 1'b0;
		// The released level needs the sync depth to drain before a later
		// status write sets the enable again.
		repeat (4) @(posedge clk);
		$display("exception test done");
	endtask
	task automatic t_win();
		wr(fec_pkg::REG_STATUS, 32'h000000ff);
		iss(fec_pkg::OP_SAVE);
		exc(6'h01, 32'h00000001);
		chk(window_q, 5'h00, "underflow window");
		wr(fec_pkg::REG_STATUS, 32'h0000077f);
		iss(fec_pkg::OP_RESTORE);
		exc(6'h02, 32'h00000702);
		wr(fec_pkg::REG_STATUS, 32'h000000bf);
		iss(fec_pkg::OP_SAVE);
		chk(nvec, nvd, "underflow gated");
		$display("window test done");
	endtask
	task automatic summarize();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_flow();
		t_mem();
		t_exc();
		t_win();
		summarize();
	end
endmodule
bind fec_flow_ctrl fec_flow_ctrl_asserts chk_i (.clk, .rst_n, .issue_valid,
	.issue, .issue_ready,
	.pc_q, .mem_q, .fault_q, .link_we_q, .vec_rd_q, .vec_addr_q, .vec_rdata,
	.vec_rvalid, .window_q, .reg_rd, .reg_rdata);
`default_nettype wire
